// ===== hdl/cfg_loader_params.svh
`ifndef CFG_LOADER_PARAMS_SVH
`define CFG_LOADER_PARAMS_SVH
// Overview of operation
// - With control field 5:4 at 01, word 30 low byte goes to port 3 register 6EH and high byte to 6FH.
// - With control field 7:6 at 01, word 31 low byte goes to register D0H and high byte to D1H.
// - With control field 9:8 at 01, words 32 to 39 fill registers B0H to BFH, low byte even, high byte odd.
// - With control field 11:10 at 01, words 40 to 47 fill registers C0H to CFH, low byte even, high odd.
// - With control field 13:12 at 01, the three low nibbles of word 49 go to bits 2:0 of 6CH of ports 0, 1, 2.
// - Under the same field, word 50 goes to registers 78H and 79H, and word 51 to 7AH and 7BH.
// - Under the same field, only bits 1:0 of word 52 go to bits 1:0 of register 7CH.
// - Each group moves only during the single load after reset and only when its field in word 16 is 01.

// Configuration word numbers.
`define W_CTRL        6'd16
`define W_UP_TAG      6'd30
`define W_VLAN_PRI    6'd31
`define W_VGRP_FIRST  6'd32
`define W_VGRP_LAST   6'd39
`define W_TOS_FIRST   6'd40
`define W_TOS_LAST    6'd47
`define W_RSVD        6'd48
`define W_PSEC        6'd49
`define W_SNOOP1      6'd50
`define W_SNOOP2      6'd51
`define W_SNOOP3      6'd52

// Control word field positions (low bit of each two-bit field).
`define F_TAG_POS     4
`define F_PRI_POS     6
`define F_VGRP_POS    8
`define F_TOS_POS     10
`define F_SEC_POS     12
`define F_ENABLE_CODE 2'b01

// Target switch registers.
`define UP_PORT       2'h3
`define R_VLAN_TAG_LO 8'h6E
`define R_VLAN_PRI_LO 8'hD0
`define R_VGRP_BASE   8'hB0
`define R_TOS_BASE    8'hC0
`define R_PSEC        8'h6C
`define R_SNOOP1_LO   8'h78
`define R_SNOOP2_LO   8'h7A
`define R_SNOOP3      8'h7C
`define M_FULL        8'hFF
`define M_PSEC        8'h07
`define M_SNOOP3      8'h03

// Bus register byte offsets.
`define A_CTRL        8'h00
`define A_STATUS      8'h04
`define A_CTLWORD     8'h08
`define A_WRCOUNT     8'h0C
`endif

// ===== hdl/cfg_loader_pkg.sv
package cfg_loader_pkg;
  typedef struct packed {
    logic       global_reg;
    logic [1:0] port;
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] mask;
  } cfg_wr_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_SCAN,
    ST_WRITE,
    ST_DONE
  } load_state_t;
endpackage

// ===== hdl/eeprom_switch_config_loader.sv
`timescale 1ns/1ps
`include "cfg_loader_params.svh"
module eeprom_switch_config_loader (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   ce,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic [31:0]                 hrdata,
  output logic                        hresp,
  output logic                        rd_req,
  output logic [5:0]                  rd_word,
  input  wire logic                   rd_ack,
  input  wire logic [15:0]            rd_data,
  output logic                        wr_valid,
  input  wire logic                   wr_ready,
  output cfg_loader_pkg::cfg_wr_t     wr_cmd,
  output logic                        load_done
);
  import cfg_loader_pkg::*;

  load_state_t state_ff;
  load_state_t nxt_state;
  logic [5:0]  word_ff;
  logic [5:0]  nxt_word;
  logic [15:0] data_ff;
  logic [15:0] ctl_ff;
  logic [1:0]  step_ff;
  logic [1:0]  nxt_step;
  cfg_wr_t     cmd_ff;
  logic [15:0] wr_cnt_ff;
  logic        pause_ff;
  logic        aphase_ff;
  logic        awrite_ff;
  logic [7:0]  aaddr_ff;
  logic [31:0] hrdata_ff;

  // Returns the bit position of the control field that governs a word.
  function automatic logic [3:0] field_pos(input logic [5:0] w);
    logic [3:0] p;
    p = 4'(`F_SEC_POS);
    if (w == `W_UP_TAG)
      p = 4'(`F_TAG_POS);
    else if (w == `W_VLAN_PRI)
      p = 4'(`F_PRI_POS);
    else if (w >= `W_VGRP_FIRST && w <= `W_VGRP_LAST)
      p = 4'(`F_VGRP_POS);
    else if (w >= `W_TOS_FIRST && w <= `W_TOS_LAST)
      p = 4'(`F_TOS_POS);
    return p;
  endfunction

  function automatic logic group_on(input logic [5:0] w, input logic [15:0] c);
    return c[field_pos(w) +: 2] == `F_ENABLE_CODE;
  endfunction

  function automatic logic [1:0] last_step(input logic [5:0] w);
    logic [1:0] n;
    n = 2'h1;
    if (w == `W_PSEC)
      n = 2'h2;
    else if (w == `W_SNOOP3)
      n = 2'h0;
    return n;
  endfunction

  // Builds the byte write for step s of word w holding data d.
  function automatic cfg_wr_t make_cmd(input logic [5:0] w, input logic [1:0] s,
                                       input logic [15:0] d);
    cfg_wr_t    c;
    logic [5:0] o;
    c.global_reg = 1'b1;
    c.port       = 2'h0;
    c.mask       = `M_FULL;
    c.data       = s[0] ? d[15:8] : d[7:0];
    c.addr       = 8'h00;
    o            = 6'h00;
    if (w == `W_UP_TAG) begin
      c.global_reg = 1'b0;
      c.port       = `UP_PORT;
      c.addr       = `R_VLAN_TAG_LO + {7'h00, s[0]};
    end else if (w == `W_VLAN_PRI) begin
      c.addr = `R_VLAN_PRI_LO + {7'h00, s[0]};
    end else if (w >= `W_VGRP_FIRST && w <= `W_VGRP_LAST) begin
      o      = w - `W_VGRP_FIRST;
      c.addr = `R_VGRP_BASE | {4'h0, o[2:0], s[0]};
    end else if (w >= `W_TOS_FIRST && w <= `W_TOS_LAST) begin
      o      = w - `W_TOS_FIRST;
      c.addr = `R_TOS_BASE | {4'h0, o[2:0], s[0]};
    end else if (w == `W_PSEC) begin
      c.global_reg = 1'b0;
      c.port       = s;
      c.addr       = `R_PSEC;
      c.mask       = `M_PSEC;
      case (s)
        2'h0:    c.data = {5'h00, d[2:0]};
        2'h1:    c.data = {5'h00, d[6:4]};
        default: c.data = {5'h00, d[10:8]};
      endcase
    end else if (w == `W_SNOOP1) begin
      c.addr = `R_SNOOP1_LO + {7'h00, s[0]};
    end else if (w == `W_SNOOP2) begin
      c.addr = `R_SNOOP2_LO + {7'h00, s[0]};
    end else if (w == `W_SNOOP3) begin
      c.addr = `R_SNOOP3;
      c.mask = `M_SNOOP3;
      c.data = {6'h00, d[1:0]};
    end
    return c;
  endfunction

  // Handshakes are gated by the clock enable so that no transfer completes while frozen.
  wire in_fetch  = (state_ff == ST_FETCH);
  wire in_write  = (state_ff == ST_WRITE);
  wire got_word  = in_fetch && rd_ack && ce;
  wire wr_accept = in_write && wr_ready && ce;
  wire cur_on    = group_on(word_ff, ctl_ff);
  wire cur_last  = (step_ff == last_step(word_ff));
  wire past_end  = (word_ff > `W_SNOOP3);

  assign rd_req    = in_fetch && ce;
  assign rd_word   = word_ff;
  assign wr_valid  = in_write && ce;
  assign wr_cmd    = cmd_ff;
  assign load_done = (state_ff == ST_DONE);

  always_comb begin
    nxt_state = state_ff;
    nxt_word  = word_ff;
    nxt_step  = step_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_state = ST_FETCH;
        nxt_word  = `W_CTRL;
      end
      ST_FETCH: begin
        if (got_word) begin
          nxt_step  = 2'h0;
          nxt_state = (word_ff == `W_CTRL) ? ST_SCAN : ST_WRITE;
          if (word_ff == `W_CTRL)
            nxt_word = `W_UP_TAG;
        end
      end
      ST_SCAN: begin
        // Disabled groups are never fetched, so their registers keep reset values.
        if (past_end)
          nxt_state = ST_DONE;
        else if (word_ff == `W_RSVD || !cur_on)
          nxt_word = word_ff + 6'h01;
        else if (!pause_ff)
          nxt_state = ST_FETCH;
      end
      ST_WRITE: begin
        if (wr_accept) begin
          if (cur_last) begin
            nxt_state = ST_SCAN;
            nxt_word  = word_ff + 6'h01;
          end else begin
            nxt_step = step_ff + 2'h1;
          end
        end
      end
      ST_DONE:
        nxt_state = ST_DONE;
      default:
        nxt_state = ST_DONE;
    endcase
  end

  wire [15:0] cmd_src  = (word_ff == `W_CTRL) ? data_ff : rd_data;
  wire        load_cmd = (got_word && word_ff != `W_CTRL) || (wr_accept && !cur_last);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ST_IDLE;
      word_ff  <= 6'h00;
      step_ff  <= 2'h0;
    end else if (ce) begin
      state_ff <= nxt_state;
      word_ff  <= nxt_word;
      step_ff  <= nxt_step;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_ff <= 16'h0000;
      ctl_ff  <= 16'h0000;
    end else if (got_word) begin
      if (word_ff == `W_CTRL)
        ctl_ff <= rd_data;
      else
        data_ff <= rd_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cmd_ff <= '0;
    else if (ce && load_cmd)
      cmd_ff <= make_cmd(word_ff, nxt_step, got_word ? cmd_src : data_ff);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      wr_cnt_ff <= 16'h0000;
    else if (wr_accept)
      wr_cnt_ff <= wr_cnt_ff + 16'h0001;
  end

  // Bus slave: zero wait states, read data registered into the data phase.
  wire        ahb_take = hsel && htrans[1] && hready && ce;
  wire [31:0] status_w = {16'h0000, 2'h0, word_ff, 5'h00, pause_ff, load_done,
                          (state_ff != ST_DONE)};
  wire [31:0] rd_mux   = (haddr[7:0] == `A_CTRL)    ? {31'h0, pause_ff} :
                         (haddr[7:0] == `A_STATUS)  ? status_w :
                         (haddr[7:0] == `A_CTLWORD) ? {16'h0000, ctl_ff} :
                         (haddr[7:0] == `A_WRCOUNT) ? {16'h0000, wr_cnt_ff} :
                         32'h00000000;
  wire        ctrl_wr  = aphase_ff && awrite_ff && (aaddr_ff == `A_CTRL) && ce;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aphase_ff <= 1'b0;
      awrite_ff <= 1'b0;
      aaddr_ff  <= 8'h00;
      hrdata_ff <= 32'h00000000;
    end else if (ce) begin
      aphase_ff <= ahb_take;
      awrite_ff <= hwrite;
      aaddr_ff  <= haddr[7:0];
      if (ahb_take && !hwrite)
        hrdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      pause_ff <= 1'b0;
    else if (ctrl_wr)
      pause_ff <= hwdata[0];
  end
endmodule

// ===== test/cfg_loader_chk.sv
`timescale 1ns/1ps
module cfg_loader_chk
  import cfg_loader_pkg::*;
(
  input wire logic                    hclk,
  input wire logic                    hresetn,
  input wire logic                    rd_req,
  input wire logic [5:0]              rd_word,
  input wire logic                    rd_ack,
  input wire logic                    wr_valid,
  input wire logic                    wr_ready,
  input wire cfg_loader_pkg::cfg_wr_t wr_cmd,
  input wire logic                    load_done
);
  import cfg_loader_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [5:0] acks_ff;
  logic [5:0] last_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acks_ff <= 6'h00;
      last_ff <= 6'h00;
    end else if (rd_req && rd_ack) begin
      acks_ff <= acks_ff + 6'h01;
      last_ff <= rd_word;
    end
  end
  first_word_a: assert property (rd_req && acks_ff == 6'h00 |-> rd_word == 6'h10)
    else $error("first fetch is not the control word");
  word_range_a: assert property (rd_req && acks_ff != 6'h00 |->
    rd_word >= 6'h1E && rd_word <= 6'h34 && rd_word != 6'h30)
    else $error("fetch outside the loaded words");
  word_order_a: assert property ($rose(rd_req) && acks_ff != 6'h00 |-> rd_word > last_ff)
    else $error("fetch order not ascending");
  req_hold_a: assert property (rd_req && !rd_ack |=> rd_req && $stable(rd_word))
    else $error("fetch request dropped early");
  req_drop_a: assert property (rd_req && rd_ack |=> !rd_req)
    else $error("fetch request held after answer");
  wr_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_cmd))
    else $error("write offer changed while stalled");
  done_quiet_a: assert property (load_done |=> load_done && !rd_req && !wr_valid)
    else $error("activity after load finished");
  psec_mask_a: assert property (wr_valid && wr_cmd.addr == 8'h6C |->
    wr_cmd.mask == 8'h07 && wr_cmd.data[7:3] == 5'h00 && !wr_cmd.global_reg)
    else $error("security write malformed");
  snoop_mask_a: assert property (wr_valid && wr_cmd.addr == 8'h7C |->
    wr_cmd.mask == 8'h03 && wr_cmd.data[7:2] == 6'h00)
    else $error("snoop write malformed");
endmodule
bind eeprom_switch_config_loader cfg_loader_chk cfg_loader_chk_i (.hclk(hclk), .hresetn(hresetn),
  .rd_req(rd_req), .rd_word(rd_word), .rd_ack(rd_ack), .wr_valid(wr_valid),
  .wr_ready(wr_ready), .wr_cmd(wr_cmd), .load_done(load_done));

// ===== test/cfg_mem_model.sv
`timescale 1ns/1ps
module cfg_mem_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        rd_req,
  input  wire logic [5:0]  rd_word,
  output logic             rd_ack,
  output logic [15:0]      rd_data
);
  logic [15:0] mem [64];
  logic [1:0]  wait_ff;
  // Latency follows the word number, so prompt and slow answers both occur.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ack  <= 1'b0;
      rd_data <= 16'h5A5A;
      wait_ff <= 2'h0;
    end else if (rd_req && !rd_ack && wait_ff == rd_word[1:0]) begin
      rd_ack  <= 1'b1;
      rd_data <= (rd_word == 6'h10) ? (mem[16] & 16'h3FFF) : mem[rd_word];
      wait_ff <= 2'h0;
    end else begin
      rd_ack  <= 1'b0;
      // Idle data toggles so a late capture cannot match by luck.
      rd_data <= ~rd_data;
      wait_ff <= (rd_req && !rd_ack) ? wait_ff + 2'h1 : 2'h0;
    end
  end
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import cfg_loader_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        rd_req, rd_ack, wr_valid, wr_ready, load_done;
  logic [31:0] haddr, hwdata, hrdata, rdv, lfsr;
  logic [1:0]  htrans;
  logic [5:0]  rd_word;
  logic [15:0] rd_data;
  cfg_wr_t     wr_cmd;
  cfg_wr_t     exp_q[$];
  logic [5:0]  word_q[$];
  int          err_total, checks_done, nwr;
  eeprom_switch_config_loader eeprom_switch_config_loader_i (.hclk(hclk), .hresetn(hresetn),
    .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .rd_req(rd_req), .rd_word(rd_word), .rd_ack(rd_ack), .rd_data(rd_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_cmd(wr_cmd), .load_done(load_done));
  cfg_mem_model cfg_mem_model_i (.hclk(hclk), .hresetn(hresetn), .rd_req(rd_req),
    .rd_word(rd_word), .rd_ack(rd_ack), .rd_data(rd_data));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] base(input int w);
    if (w == 30) return 8'h6E;
    if (w == 31) return 8'hD0;
    if (w < 40) return 8'hB0 + 8'(2 * (w - 32));
    if (w < 48) return 8'hC0 + 8'(2 * (w - 40));
    return (w == 50) ? 8'h78 : 8'h7A;
  endfunction
  function automatic int fpos(input int w);
    return (w == 30) ? 4 : (w == 31) ? 6 : (w < 40) ? 8 : (w < 48) ? 10 : 12;
  endfunction
  task cmp32(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task cmpw(input cfg_wr_t g, input cfg_wr_t e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task add(input logic g, input int p, input int a, input logic [7:0] d, input logic [7:0] m);
    exp_q.push_back(cfg_wr_t'{g, 2'(p), 8'(a), d, m});
    nwr++;
  endtask
  task start(input logic [15:0] c);
    logic [15:0] v;
    hresetn <= 1'b0;
    exp_q.delete();
    word_q.delete();
    nwr = 0;
    word_q.push_back(6'h10);
    cfg_mem_model_i.mem[16] = c;
    for (int w = 30; w <= 52; w++) begin
      @(negedge hclk);
      v = lfsr[15:0];
      cfg_mem_model_i.mem[w] = v;
      if (w != 48 && c[fpos(w)+:2] == 2'b01) begin
        word_q.push_back(6'(w));
        if (w == 49) for (int p = 0; p < 3; p++) add(0, p, 'h6C, {5'h00, v[4*p+:3]}, 8'h07);
        else if (w == 52) add(1, 0, 'h7C, {6'h00, v[1:0]}, 8'h03);
        else begin
          add(w > 30, (w == 30) ? 3 : 0, base(w), v[7:0], 8'hFF);
          add(w > 30, (w == 30) ? 3 : 0, base(w) + 1, v[15:8], 8'hFF);
        end
      end
    end
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
  task finish(input logic [15:0] c);
    for (int i = 0; i < 1000 && load_done !== 1'b1; i++) @(posedge hclk);
    cmp32(32'(exp_q.size()), 32'h0);
    ahb(1'b0, 8'h04, 32'h0);
    cmp32(rdv & 32'h7, 32'h2);
    ahb(1'b0, 8'h08, 32'h0);
    cmp32(rdv, {16'h0000, c});
    ahb(1'b0, 8'h0C, 32'h0);
    cmp32(rdv, 32'(nwr));
  endtask
  task end_of_test;
    $display("checks=%0d errors=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    lfsr <= nxt(lfsr);
    wr_ready <= lfsr[0] | lfsr[1];
    if (hresetn && wr_valid && wr_ready)
      cmpw(wr_cmd, exp_q.size() ? exp_q.pop_front() : cfg_wr_t'(0));
    if (hresetn && rd_req && rd_ack)
      cmp32(32'(rd_word), 32'(word_q.size() ? word_q.pop_front() : 6'h3F));
  end
  initial begin
    #100us;
    err_total++;
    end_of_test;
  end
  initial begin
    {hresetn, hsel, hwrite, wr_ready, htrans, haddr, hwdata} = '0;
    {err_total, checks_done, nwr} = '0;
    lfsr = 32'hFD3B01E2;
    start(16'h1555);
    ahb(1'b1, 8'h00, 32'h1);
    ahb(1'b0, 8'h04, 32'h0);
    cmp32(rdv & 32'h7, 32'h5);
    ahb(1'b0, 8'h10, 32'h0);
    cmp32(rdv, 32'h0);
    // A second reset while paused must restart the load from the control word.
    start(16'h1555);
    finish(16'h1555);
    start(16'h1361);
    finish(16'h1361);
    start(16'h0000);
    finish(16'h0000);
    repeat (4) begin
      rdv = lfsr & 32'h3FFF;
      start(rdv[15:0]);
      finish(rdv[15:0]);
    end
    end_of_test;
  end
endmodule
